// [rtl/frame_check_if.sv]
`timescale 1ns/1ps
interface frame_check_if #(
    parameter int N = 14
);
    logic         frame;
    logic [N-1:0] packet;
    logic [1:0]   rc;
    logic [N-1:0] prot_in;
    logic         resync;
    logic         valid;
    logic         rc_err;
    logic         prot_err;
    logic         seeded;
    logic [N-1:0] calc;

    modport checker_end (
        input  frame, packet, rc, prot_in, resync,
        output valid, rc_err, prot_err, seeded, calc
    );
    modport window_end (
        output frame, packet, rc, prot_in, resync,
        input  valid, rc_err, prot_err, seeded, calc
    );
endinterface

// [rtl/frame_integrity_check.sv]
`timescale 1ns/1ps
module frame_integrity_check
    import sig_verify_pkg::*;
#(
    parameter int N = PACKET_W_DEF
) (
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    frame_check_if.checker_end     chk
);

    typedef struct packed {
        logic         valid;
        logic         seeded;
        logic [1:0]   expect_rc;
        logic         rc_err;
        logic         prot_err;
        logic [N-1:0] calc;
    } chk_state_t;

    chk_state_t s_r;
    chk_state_t s_nxt;

    // ==========================================================
    // Protection value: negated n-bit sum, carries dropped
    function automatic logic [N-1:0] prot_value(
        input logic [N-1:0] pkt,
        input logic [1:0]   rc
    );
        logic [N-1:0] sum;
        sum = pkt + N'(rc);
        return ~sum + N'(1);
    endfunction

    always_comb begin
        s_nxt       = s_r;
        s_nxt.valid = 1'b0;
        if (chk.resync) begin
            s_nxt.seeded = 1'b0;
        end
        if (chk.frame) begin
            s_nxt.valid    = 1'b1;
            s_nxt.calc     = prot_value(chk.packet, chk.rc);
            s_nxt.prot_err = (chk.prot_in != s_nxt.calc);
            // First count after start only seeds the expectation
            s_nxt.rc_err    = s_r.seeded && !chk.resync && (chk.rc != s_r.expect_rc);
            s_nxt.expect_rc = chk.rc + 2'h1;
            s_nxt.seeded    = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign chk.valid    = s_r.valid;
    assign chk.rc_err   = s_r.rc_err;
    assign chk.prot_err = s_r.prot_err;
    assign chk.seeded   = s_r.seeded;
    assign chk.calc     = s_r.calc;

endmodule

// [rtl/sig_verify_pkg.sv]
package sig_verify_pkg;

    // ==========================================================
    // Frame format and window defaults
    localparam int PACKET_W_DEF = 14;
    localparam int THRESH_DEF   = 3;
    localparam int WINDOW_DEF   = 10;
    localparam int RC_W         = 2;

    // ==========================================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CALC_PROT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FRAME_CNT = 8'h14;

    localparam int CTRL_EN_BIT       = 0;
    localparam int CTRL_RESYNC_BIT   = 1;
    localparam int CTRL_SAFE_CLR_BIT = 2;
    localparam logic CTRL_EN_RESET   = 1'b1;

    localparam int ST_WIN_BIT       = 0;
    localparam int ST_VERIFY_BIT    = 1;
    localparam int ST_RC_BIT        = 2;
    localparam int ST_PROT_BIT      = 3;
    localparam int ST_SEEDED_BIT    = 4;
    localparam int ST_SAFE_BIT      = 5;
    localparam int ST_DISCARD_BIT   = 6;
    localparam int ST_TOTAL_LSB     = 8;
    localparam int ST_INDEX_LSB     = 16;

    localparam int IRQ_W          = 2;
    localparam int IRQ_VERIFY_BIT = 0;
    localparam int IRQ_WIN_BIT    = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 2'h0;

    localparam int FRAME_CNT_W = 16;

    // Sticky update: a set in the clearing cycle survives
    function automatic logic [IRQ_W-1:0] sticky_upd(
        input logic [IRQ_W-1:0] cur,
        input logic [IRQ_W-1:0] clr,
        input logic [IRQ_W-1:0] set
    );
        return (cur & ~clr) | set;
    endfunction

endpackage

// [rtl/signal_verification_checker.sv]
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - Recompute protection value from received packet and rolling counter.
// - Flag protection mismatch when received value differs from computed.
// - Offer per-frame discard qualifier for frames with protection mismatch.
// - Verification error when rolling counter error or protection mismatch.
// - Per-frame verification error visible separately from window result.
// - Window error when X errors lie within last Y frames.
// - X and Y are parameters, defaults 3 and 10.
// - X limited to Y/2 (even Y) or (Y+1)/2 (odd Y).
// - Start clears history, frame index, window total and window flag.
// - Retire oldest entry: decrement total if history slot is set.
// - Error frame sets slot and increments total, else slot cleared.
// - Window flag equals total at least X, re-evaluated each frame.
// - Frame index advances after every received frame.
// - Window error may force a safe state held until cycle ends; here software can release it via CTRL_SAFE_CLR_BIT.
// - Protection is n-bit two's complement of packet plus counter.
// - Expected counter is previous received plus one modulo 4.
// - First counter after start only seeds, never raises error.
module signal_verification_checker
    import sig_verify_pkg::*;
#(
    parameter int PACKET_W = PACKET_W_DEF,
    parameter int THRESH   = THRESH_DEF,
    parameter int WINDOW   = WINDOW_DEF
) (
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_frame_valid,
    input  wire logic [PACKET_W-1:0] i_packet,
    input  wire logic [RC_W-1:0]     i_rolling_counter,
    input  wire logic [PACKET_W-1:0] i_protection,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [DATA_W-1:0]   i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic [DATA_W-1:0]        o_rdata,
    output logic                     o_irq,
    output logic                     o_frame_done,
    output logic                     o_verify_err,
    output logic                     o_rc_err,
    output logic                     o_prot_err,
    output logic                     o_discard,
    output logic                     o_window_err,
    output logic                     o_safe_state
);

    // ==========================================================
    // Window sizing
    // Integer (Y+1)/2 equals Y/2 for even Y, so one cap serves both
    localparam int THRESH_CAP = (WINDOW + 1) / 2;
    localparam int THRESH_EFF = (THRESH < THRESH_CAP) ? THRESH : THRESH_CAP;
    localparam int TOT_W      = $clog2(WINDOW + 1);
    localparam int IDX_W      = (WINDOW > 1) ? $clog2(WINDOW) : 1;
    localparam logic [TOT_W-1:0] THRESH_VAL = TOT_W'(THRESH_EFF);
    localparam logic [IDX_W-1:0] IDX_LAST   = IDX_W'(WINDOW - 1);

    // ==========================================================
    // State
    typedef struct packed {
        logic                    en;
        logic                    resync;
        logic [WINDOW-1:0]       hist;
        logic [IDX_W-1:0]        idx;
        logic [TOT_W-1:0]        total;
        logic                    win_err;
        logic                    safe;
        logic                    verify_err;
        logic                    rc_err;
        logic                    prot_err;
        logic                    discard;
        logic                    done;
        logic [FRAME_CNT_W-1:0]  frame_cnt;
        logic [IRQ_W-1:0]        irq_stat;
        logic [IRQ_W-1:0]        irq_mask;
        logic                    irq;
        logic [DATA_W-1:0]       rdata;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    frame_check_if #(.N(PACKET_W)) chk ();

    frame_integrity_check #(
        .N (PACKET_W)
    ) u_check (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .chk      (chk.checker_end)
    );

    // ==========================================================
    // Frame feed to the checker
    // Disabled block ignores frames entirely, counter state included
    assign chk.frame   = i_frame_valid & s_r.en;
    assign chk.packet  = i_packet;
    assign chk.rc      = i_rolling_counter;
    assign chk.prot_in = i_protection;
    assign chk.resync  = s_r.resync;

    // ==========================================================
    // Register read mux
    function automatic logic [DATA_W-1:0] read_word(
        input top_state_t         st,
        input logic [ADDR_W-1:0]  addr,
        input logic               seeded,
        input logic [PACKET_W-1:0] calc
    );
        logic [DATA_W-1:0] w;
        w = '0;
        unique case (addr)
            OFS_CTRL: begin
                w[CTRL_EN_BIT] = st.en;
            end
            OFS_STATUS: begin
                w[ST_WIN_BIT]     = st.win_err;
                w[ST_VERIFY_BIT]  = st.verify_err;
                w[ST_RC_BIT]      = st.rc_err;
                w[ST_PROT_BIT]    = st.prot_err;
                w[ST_SEEDED_BIT]  = seeded;
                w[ST_SAFE_BIT]    = st.safe;
                w[ST_DISCARD_BIT] = st.discard;
                w[ST_TOTAL_LSB +: TOT_W] = st.total;
                w[ST_INDEX_LSB +: IDX_W] = st.idx;
            end
            OFS_IRQ_STAT: begin
                w[IRQ_W-1:0] = st.irq_stat;
            end
            OFS_IRQ_MASK: begin
                w[IRQ_W-1:0] = st.irq_mask;
            end
            OFS_CALC_PROT: begin
                w[PACKET_W-1:0] = calc;
            end
            OFS_FRAME_CNT: begin
                w[FRAME_CNT_W-1:0] = st.frame_cnt;
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    // ==========================================================
    // Next state
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic              frame_err;
    logic              slot_old;
    logic [TOT_W-1:0]  total_ret;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;

    always_comb begin
        s_nxt     = s_r;
        wr_ctrl   = i_wr && (i_addr == OFS_CTRL);
        wr_stat   = i_wr && (i_addr == OFS_IRQ_STAT);
        wr_mask   = i_wr && (i_addr == OFS_IRQ_MASK);
        frame_err = chk.rc_err | chk.prot_err;
        slot_old  = s_r.hist[s_r.idx];
        total_ret = s_r.total;
        irq_set   = '0;
        irq_clr   = '0;

        s_nxt.done   = 1'b0;
        s_nxt.resync = 1'b0;
        s_nxt.rdata  = '0;

        // Software control
        if (wr_ctrl) begin
            s_nxt.en     = i_wdata[CTRL_EN_BIT];
            s_nxt.resync = i_wdata[CTRL_RESYNC_BIT];
        end
        if (wr_mask) begin
            s_nxt.irq_mask = i_wdata[IRQ_W-1:0];
        end
        if (wr_stat) begin
            irq_clr = i_wdata[IRQ_W-1:0];
        end

        // Per-frame accounting, one cycle after the checker
        if (chk.valid) begin
            if (slot_old) begin
                total_ret = s_r.total - TOT_W'(1);
            end
            s_nxt.hist[s_r.idx] = frame_err;
            if (frame_err) begin
                s_nxt.total = total_ret + TOT_W'(1);
            end else begin
                s_nxt.total = total_ret;
            end
            s_nxt.win_err    = (s_nxt.total >= THRESH_VAL);
            s_nxt.verify_err = frame_err;
            s_nxt.rc_err     = chk.rc_err;
            s_nxt.prot_err   = chk.prot_err;
            s_nxt.discard    = chk.prot_err;
            s_nxt.done       = 1'b1;
            if (s_r.idx == IDX_LAST) begin
                s_nxt.idx = '0;
            end else begin
                s_nxt.idx = s_r.idx + IDX_W'(1);
            end
            s_nxt.frame_cnt = s_r.frame_cnt + FRAME_CNT_W'(1);
            irq_set[IRQ_VERIFY_BIT] = frame_err;
            irq_set[IRQ_WIN_BIT]    = s_nxt.win_err && !s_r.win_err;
        end

        // Safe state holds until reset or explicit software release
        if (wr_ctrl && i_wdata[CTRL_SAFE_CLR_BIT]) begin
            s_nxt.safe = 1'b0;
        end
        if (s_nxt.win_err) begin
            s_nxt.safe = 1'b1;
        end

        s_nxt.irq_stat = sticky_upd(s_r.irq_stat, irq_clr, irq_set);
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);

        if (i_rd) begin
            s_nxt.rdata = read_word(s_r, i_addr, chk.seeded, chk.calc);
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r          <= '0;
            s_r.en       <= CTRL_EN_RESET;
            s_r.irq_stat <= IRQ_STAT_RESET;
            s_r.irq_mask <= IRQ_MASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign o_rdata      = s_r.rdata;
    assign o_irq        = s_r.irq;
    assign o_frame_done = s_r.done;
    assign o_verify_err = s_r.verify_err;
    assign o_rc_err     = s_r.rc_err;
    assign o_prot_err   = s_r.prot_err;
    assign o_discard    = s_r.discard;
    assign o_window_err = s_r.win_err;
    assign o_safe_state = s_r.safe;

endmodule

// [verif/sig_verify_monitor.sv]
`timescale 1ns/1ps
module sig_verify_monitor
    import sig_verify_pkg::*;
#(
    parameter int PACKET_W = PACKET_W_DEF,
    parameter int THRESH   = THRESH_DEF,
    parameter int WINDOW   = WINDOW_DEF
) (
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_frame_valid,
    input  wire logic [PACKET_W-1:0] i_packet,
    input  wire logic [RC_W-1:0]     i_rolling_counter,
    input  wire logic [PACKET_W-1:0] i_protection,
    input  wire logic                i_rd,
    input  wire logic [ADDR_W-1:0]   i_addr,
    input  wire logic [DATA_W-1:0]   i_wdata,
    input  wire logic                i_wr,
    input  wire logic [DATA_W-1:0]   o_rdata,
    input  wire logic                o_frame_done,
    input  wire logic                o_verify_err,
    input  wire logic                o_rc_err,
    input  wire logic                o_prot_err,
    input  wire logic                o_discard,
    input  wire logic                o_window_err,
    input  wire logic                o_safe_state
);
    // ==========================================================
    // Reference results, delayed to meet the two-cycle answer
    logic [PACKET_W-1:0] exp_prot;
    logic [RC_W-1:0]     exp_rc_r;
    logic                seeded_r;
    logic [1:0]          err_d1_r;
    logic [1:0]          err_d2_r;
    logic                en_r;
    logic                taken;

    assign exp_prot = ~(i_packet + PACKET_W'(i_rolling_counter)) + PACKET_W'(1);
    // A disabled block drops frames, so only enabled ones are answered
    assign taken    = i_frame_valid && en_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            exp_rc_r <= '0;
            seeded_r <= 1'b0;
            err_d1_r <= 2'h0;
            err_d2_r <= 2'h0;
            en_r     <= CTRL_EN_RESET;
        end else begin
            err_d2_r <= err_d1_r;
            err_d1_r <= 2'h0;
            if (taken) begin
                err_d1_r <= {seeded_r && (i_rolling_counter != exp_rc_r),
                             i_protection != exp_prot};
                exp_rc_r <= i_rolling_counter + 2'h1;
                seeded_r <= 1'b1;
            end
            // Control write wins over a frame taken on the same edge
            if (i_wr && (i_addr == OFS_CTRL)) begin
                en_r <= i_wdata[CTRL_EN_BIT];
                if (i_wdata[CTRL_RESYNC_BIT]) begin
                    seeded_r <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_answer;
        ##2 o_frame_done;
    endsequence
    sequence s_frame_taken;
        taken;
    endsequence

    a_done_latency: assert property (s_frame_taken |-> s_answer)
        else $error("frame answer missing two cycles after take");
    a_done_cause: assert property (o_frame_done |-> $past(taken, 2))
        else $error("frame done without a frame");
    a_prot_result: assert property (o_frame_done |-> o_prot_err == err_d2_r[0])
        else $error("protection mismatch flag wrong");
    a_rc_result: assert property (o_frame_done |-> o_rc_err == err_d2_r[1])
        else $error("rolling counter flag wrong");
    a_verify_merge: assert property (o_verify_err == (o_rc_err || o_prot_err))
        else $error("verify error not the merge of both checks");
    a_discard_prot: assert property (o_discard == o_prot_err)
        else $error("discard qualifier differs from protection flag");
    a_results_hold: assert property (!o_frame_done |-> $stable({o_verify_err, o_window_err}))
        else $error("frame results moved between frames");
    a_window_rise: assert property ($rose(o_window_err) |-> o_frame_done && o_verify_err)
        else $error("window error rose without an error frame");
    a_safe_follow: assert property (o_window_err |-> o_safe_state)
        else $error("safe state missing during window error");
    a_read_quiet: assert property ($past(i_rd) == 1'b0 |-> o_rdata == '0)
        else $error("read data outside its cycle");
endmodule

bind signal_verification_checker sig_verify_monitor #(
    .PACKET_W(PACKET_W), .THRESH(THRESH), .WINDOW(WINDOW)
) u_monitor (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_frame_valid(i_frame_valid),
    .i_packet(i_packet), .i_rolling_counter(i_rolling_counter),
    .i_protection(i_protection), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .o_frame_done(o_frame_done), .o_verify_err(o_verify_err), .o_rc_err(o_rc_err),
    .o_prot_err(o_prot_err), .o_discard(o_discard), .o_window_err(o_window_err),
    .o_safe_state(o_safe_state)
);

// [verif/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module testbench
    import sig_verify_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_resetn, req, bad_prot, bad_rc, frame_valid, i_wr, i_rd, o_irq, o_frame_done;
    logic o_verify_err, o_rc_err, o_prot_err, o_discard, o_window_err, o_safe_state;
    logic [13:0] pkt, packet, prot;
    logic [1:0] rc;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, rdv;
    int errors, checks_done;

    always #10 i_clk = ~i_clk;

    signal_verification_checker u_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_frame_valid(frame_valid),
        .i_packet(packet), .i_rolling_counter(rc), .i_protection(prot),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_frame_done(o_frame_done),
        .o_verify_err(o_verify_err), .o_rc_err(o_rc_err), .o_prot_err(o_prot_err),
        .o_discard(o_discard), .o_window_err(o_window_err), .o_safe_state(o_safe_state));
    tx_node_model u_tx (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .i_pkt(pkt),
        .i_bad_prot(bad_prot), .i_bad_rc(bad_rc), .o_frame_valid(frame_valid),
        .o_packet(packet), .o_rolling_counter(rc), .o_protection(prot));

    // ==========================================================
    // Bus and frame tasks
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk); i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_clk); i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_clk); i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk); i_rd <= 1'b0;
        #1 rdv = o_rdata;
    endtask
    task automatic send(input logic [13:0] p, input logic bp, input logic br);
        int n;
        @(posedge i_clk); req <= 1'b1; pkt <= p; bad_prot <= bp; bad_rc <= br;
        @(posedge i_clk); req <= 1'b0;
        #1;
        for (n = 0; n < 8 && o_frame_done !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        `CHK("frame_done", 1'b1, o_frame_done)
    endtask
    task automatic do_reset();
        @(posedge i_clk); i_resetn <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge i_clk);
        #1 `CHK("irq", v, o_irq)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd(OFS_CTRL);       `CHK("ctrl_en", CTRL_EN_RESET, rdv[CTRL_EN_BIT])
        rd(OFS_IRQ_MASK);   `CHK("irq_mask", 32'h0, rdv)
        rd(OFS_IRQ_STAT);   `CHK("irq_stat", 32'h0, rdv)
        rd(8'h20);          `CHK("unmapped", 32'h0, rdv)
        wr(OFS_IRQ_MASK, 32'h3);
        rd(OFS_IRQ_MASK);   `CHK("irq_mask", 32'h3, rdv)
        wr(OFS_IRQ_MASK, 32'h1);
    endtask
    task automatic t_example();
        send(14'h2FEC, 1'b0, 1'b0);
        `CHK("rc_err", 1'b0, o_rc_err)
        `CHK("prot_err", 1'b0, o_prot_err)
        rd(OFS_CALC_PROT);  `CHK("calc_prot", 32'h1012, rdv)
        send(14'h2FEC, 1'b1, 1'b0);
        `CHK("prot_err", 1'b1, o_prot_err)
        `CHK("discard", 1'b1, o_discard)
        `CHK("verify_err", 1'b1, o_verify_err)
        `CHK("window_err", 1'b0, o_window_err)
        irq_is(1'b1);
        wr(OFS_IRQ_STAT, 32'h1);
        irq_is(1'b0);
    endtask
    task automatic t_rc();
        send(14'h0155, 1'b0, 1'b1);
        `CHK("rc_err", 1'b1, o_rc_err)
        `CHK("prot_err", 1'b0, o_prot_err)
        `CHK("verify_err", 1'b1, o_verify_err)
        send(14'h0156, 1'b0, 1'b0);
        `CHK("rc_err", 1'b0, o_rc_err)
    endtask
    task automatic t_window();
        logic [34:0] em;
        logic [34:0] wm;
        int f;
        em = 35'h084480800;
        wm = 35'h09C000000;
        do_reset();
        wr(OFS_IRQ_MASK, 32'h2);
        for (f = 1; f <= 34; f++) begin
            send(14'(f), em[f], 1'b0);
            `CHK("verify_err", em[f], o_verify_err)
            `CHK("window_err", wm[f], o_window_err)
            `CHK("safe_state", f >= 26, o_safe_state)
        end
        rd(OFS_STATUS);
        `CHK("frame_index", 4'h4, rdv[ST_INDEX_LSB +: 4])
        `CHK("window_total", 4'h2, rdv[ST_TOTAL_LSB +: 4])
        irq_is(1'b1);
        wr(OFS_IRQ_STAT, 32'h2);
        irq_is(1'b0);
    endtask
    task automatic t_ctrl();
        wr(OFS_CTRL, 32'h5);
        rd(OFS_STATUS);     `CHK("safe_release", 1'b0, rdv[ST_SAFE_BIT])
        `CHK("safe_state", 1'b0, o_safe_state)
        rd(OFS_FRAME_CNT);  `CHK("frame_count", 32'h22, rdv)
        wr(OFS_CTRL, 32'h0);
        // Disabled block drops this frame; the sender's count still moves on
        @(posedge i_clk); req <= 1'b1; bad_prot <= 1'b1;
        @(posedge i_clk); req <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 `CHK("dropped_done", 1'b0, o_frame_done)
        wr(OFS_CTRL, 32'h3);
        send(14'h0AAA, 1'b0, 1'b0);
        `CHK("resync_rc_err", 1'b0, o_rc_err)
        rd(OFS_FRAME_CNT);  `CHK("frame_count", 32'h23, rdv)
    endtask

    // ==========================================================
    // Verdict
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        i_resetn = 1'b0; req = 1'b0; pkt = '0; bad_prot = 1'b0; bad_rc = 1'b0;
        i_addr = '0; i_wdata = '0; i_wr = 1'b0; i_rd = 1'b0;
        errors = 0; checks_done = 0;
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_example();
        t_rc();
        t_window();
        t_ctrl();
        wrap_up();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        wrap_up();
    end
endmodule

// [verif/tx_node_model.sv]
`timescale 1ns/1ps
module tx_node_model
    import sig_verify_pkg::*;
#(
    parameter int              PACKET_W = PACKET_W_DEF,
    parameter logic [RC_W-1:0] RC_START = 2'h2
) (
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_req,
    input  wire logic [PACKET_W-1:0] i_pkt,
    input  wire logic                i_bad_prot,
    input  wire logic                i_bad_rc,
    output logic                     o_frame_valid,
    output logic [PACKET_W-1:0]      o_packet,
    output logic [RC_W-1:0]          o_rolling_counter,
    output logic [PACKET_W-1:0]      o_protection
);
    logic [RC_W-1:0] rc_r;
    logic [RC_W-1:0] rc_use;

    // A skipped count still gets a matching protection value
    assign rc_use = i_bad_rc ? rc_r + 2'h1 : rc_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rc_r              <= RC_START;
            o_frame_valid     <= 1'b0;
            o_packet          <= '0;
            o_rolling_counter <= '0;
            o_protection      <= '0;
        end else if (i_req) begin
            o_frame_valid     <= 1'b1;
            o_packet          <= i_pkt;
            o_rolling_counter <= rc_use;
            o_protection      <= (~(i_pkt + PACKET_W'(rc_use)) + PACKET_W'(1))
                                 ^ PACKET_W'(i_bad_prot);
            rc_r              <= rc_use + 2'h1;
        end else begin
            // Lines outside a frame carry no valid value
            o_frame_valid     <= 1'b0;
            o_packet          <= ~o_packet;
            o_rolling_counter <= ~o_rolling_counter;
            o_protection      <= ~o_protection;
        end
    end
endmodule
